// file: common/ccs_pkg.sv
/*
 Constants, pin bundle and power states for the card condition/status register block.
 Assumes a single 125 MHz system clock; all card bus pins arrive asynchronously.
*/
// What this block does
// - Changed summary reads one when either change flag is one.
// - In I/O mode status output low when changed and enable set; high if enable clear.
// - Byte-I/O request bit is stored but never alters access handling.
// - Power-level-disable bit reads zero, resets zero, ignores writes.
// - Power-save request one enters power-down; zero returns to active.
// - Ready goes busy on any power-save request change until state reached.
// - Card powers down automatically when idle, wakes on a command.
// - Interrupt-pending bit mirrors internal request; zero while interrupts disabled.
// - Pin register reads D7,D6 zero, D3,D2 one, raw write-lock zero.
// - Ready-change flag sets whenever raw ready state changes.
// - Lock-change flag sets whenever raw write-lock state changes.
// - Raw ready bit reflects the internal ready signal.
// - Change flag takes written value only when its mask bit is one.
// - Unit bit reads back as written and is matched against unit select.
// - Socket number field D3-D0 is ignored on writes.
// - Wide-port acknowledge asserted for every responding I/O address.
// - Wait asserted at start of an input cycle until data is ready.
// - Byte enables and A0 steer bytes per lane; attribute select high inhibits I/O.
// - Index 0 memory-mapped; 1 any block, 2 primary, 3 secondary I/O.
// - Configuration registers sit at attribute base 200h, even byte addresses only.
package ccs_pkg;

    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned PWR_SETTLE_NS = 1000;
    localparam int unsigned PWR_SETTLE_CYC = (PWR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned IDLE_TIMEOUT_NS = 1000000;
    localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_NS / CLK_PERIOD_NS;

    localparam logic [10:0] ATTR_BASE = 11'h200;
    localparam logic [3:0] OFS_CARD_COND = 4'h2;
    localparam logic [3:0] OFS_PIN_REPL = 4'h4;
    localparam logic [3:0] OFS_SOCKET = 4'h6;

    localparam int CC_CHANGED = 7;
    localparam int CC_SIG_EN = 6;
    localparam int CC_BYTE_IO = 5;
    localparam int CC_PWR_LVL_DIS = 4;
    localparam int CC_AUDIO = 3;
    localparam int CC_PWR_SAVE = 2;
    localparam int CC_INT = 1;

    localparam int PR_RDY_CHG = 5;
    localparam int PR_LOCK_CHG = 4;
    localparam int PR_RDY_RAW = 1;
    localparam int PR_LOCK_RAW = 0;
    localparam logic [7:0] PR_FIXED_ONES = 8'h0C;
    localparam logic RAW_LOCK_VAL = 1'b0;
    localparam logic PWR_LVL_DIS_VAL = 1'b0;

    localparam int SK_UNIT = 4;

    localparam logic [5:0] CFG_MEMORY = 6'h00;
    localparam logic [5:0] CFG_IO_ANY = 6'h01;
    localparam logic [5:0] CFG_IO_PRI = 6'h02;
    localparam logic [5:0] CFG_IO_SEC = 6'h03;
    localparam logic [9:0] IO_PRI_TASK = 10'h1F0;
    localparam logic [9:0] IO_PRI_CTL = 10'h3F6;
    localparam logic [9:0] IO_SEC_TASK = 10'h170;
    localparam logic [9:0] IO_SEC_CTL = 10'h376;

    typedef enum logic [1:0] {
        CCS_ACTIVE,
        CCS_ENTER_SAVE,
        CCS_SAVE,
        CCS_LEAVE_SAVE
    } ccs_pwr_e;

    typedef struct packed {
        logic reg_n;
        logic hi_en_n;
        logic lo_en_n;
        logic oe_n;
        logic we_n;
        logic io_rd_n;
        logic io_wr_n;
        logic [10:0] addr;
        logic [15:0] data;
    } ccs_pins_s;

    localparam ccs_pins_s PINS_IDLE = {7'h7F, 11'h000, 16'h0000};

endpackage

// file: common/ccs_lane_if.sv
/*
 Byte-lane steering bundle between the register block and its lane steering module.
 Assumes both ends sit on the same clock; the bundle itself is purely combinational.
*/
`timescale 1ns/100ps
interface ccs_lane_if;
    logic lo_en;
    logic hi_en;
    logic a0;
    logic [15:0] rd_word;
    logic [15:0] bus_in;
    logic [15:0] rd_bus;
    logic [1:0] drive;
    logic wr_even;
    logic wr_odd;
    logic [15:0] wr_word;

    modport steer (
        input lo_en, hi_en, a0, rd_word, bus_in,
        output rd_bus, drive, wr_even, wr_odd, wr_word
    );
    modport ctl (
        output lo_en, hi_en, a0, rd_word, bus_in,
        input rd_bus, drive, wr_even, wr_odd, wr_word
    );
endinterface // ccs_lane_if

// file: rtl/ccs_lane.sv
/*
 Byte-lane steering for I/O cycles: maps word data onto the two data lanes.
 Assumes enables are active high here and already synchronised by the caller.
*/
`timescale 1ns/100ps
module ccs_lane (
    ccs_lane_if.steer lane
);
    logic lo_only;

    always_comb begin
        lo_only = lane.lo_en && !lane.hi_en;
        // Low lane alone carries even or odd byte by A0; otherwise even byte
        lane.rd_bus[7:0] = (lo_only && lane.a0) ? lane.rd_word[15:8] : lane.rd_word[7:0];
        lane.rd_bus[15:8] = lane.rd_word[15:8];
        lane.drive = {lane.hi_en, lane.lo_en};
        lane.wr_even = lane.lo_en && (lane.hi_en || !lane.a0);
        lane.wr_odd = lane.hi_en || (lo_only && lane.a0);
        lane.wr_word[7:0] = lane.bus_in[7:0];
        lane.wr_word[15:8] = lane.hi_en ? lane.bus_in[15:8] : lane.bus_in[7:0];
    end
endmodule // ccs_lane

// file: rtl/ccs_regs.sv
/*
 Card condition/status, pin replacement and socket registers plus I/O cycle handling.
 Assumes card bus pins are asynchronous, core-side signals share sys_clk, and the
 configuration index comes from the option register elsewhere on the same clock.
*/
`timescale 1ns/100ps
module ccs_regs import ccs_pkg::*; #(
    parameter int unsigned IDLE_CYCLES = IDLE_TIMEOUT_CYC,
    parameter int unsigned SETTLE_CYCLES = PWR_SETTLE_CYC,
    parameter bit HAS_UNIT_SELECT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic reg_sel_n,
    input wire logic low_byte_enable_n,
    input wire logic high_byte_enable_n,
    input wire logic mem_read_n,
    input wire logic mem_write_n,
    input wire logic io_read_strobe_n,
    input wire logic io_write_strobe_n,
    input wire logic [10:0] card_addr,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic [1:0] data_oe_n,
    output logic wide_port_ack_n,
    output logic wait_n,
    output logic status_change_out_n,
    output logic ready_irq_n,
    input wire logic [5:0] config_index,
    input wire logic core_ready,
    input wire logic core_irq,
    input wire logic irq_disable_ctl,
    input wire logic core_idle,
    input wire logic core_cmd,
    input wire logic unit_select_bit,
    input wire logic [15:0] io_rd_data,
    input wire logic io_rd_valid,
    output logic io_rd_req,
    output logic io_wr_pulse,
    output logic [3:0] io_addr,
    output logic [15:0] io_wr_data,
    output logic [1:0] io_wr_lanes,
    output logic power_down,
    output logic unit_match
);
    localparam int unsigned CNT_MAX = (IDLE_CYCLES > SETTLE_CYCLES) ? IDLE_CYCLES : SETTLE_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);
    localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        ccs_pins_s s1;
        ccs_pins_s s2;
        ccs_pins_s prev;
        logic sig_en;
        logic byte_io;
        logic audio;
        logic pwr_req;
        logic rdy_chg;
        logic lock_chg;
        logic unit;
        logic prev_ready;
        logic prev_lock;
        logic auto_save;
        ccs_pwr_e pwr;
        logic [CNT_W-1:0] cnt;
        logic rd_pend;
        logic wait_n;
        logic ack_n;
        logic stat_chg_n;
        logic rdy_irq_n;
        logic [15:0] dout;
        logic [1:0] doe_n;
        logic rd_req;
        logic wr_pulse;
        logic [3:0] addr;
        logic [15:0] wr_data;
        logic [1:0] wr_lanes;
        logic match;
    } ccs_state_s;

    ccs_state_s q;
    ccs_state_s d;
    ccs_lane_if lane ();

    ccs_lane u_lane (
        .lane(lane.steer)
    );

    function automatic logic attr_hit(input ccs_pins_s p);
        // Word-wide attribute reads still use only the even byte on the low lane
        return !p.reg_n && !p.lo_en_n && !p.addr[0] && (p.addr[10:4] == ATTR_BASE[10:4]);
    endfunction

    function automatic logic io_hit(input ccs_pins_s p, input logic [5:0] idx);
        logic m;
        m = 1'b0;
        unique case (idx)
            CFG_IO_ANY: m = 1'b1;
            CFG_IO_PRI: m = (p.addr[9:3] == IO_PRI_TASK[9:3]) || (p.addr[9:1] == IO_PRI_CTL[9:1]);
            CFG_IO_SEC: m = (p.addr[9:3] == IO_SEC_TASK[9:3]) || (p.addr[9:1] == IO_SEC_CTL[9:1]);
            default: m = 1'b0;
        endcase
        // Attribute select high inhibits every I/O cycle
        return m && !p.reg_n && !(p.lo_en_n && p.hi_en_n);
    endfunction

    logic io_mode;
    logic ready_now;
    logic int_pending;
    logic changed;
    logic attr_wr;
    logic [7:0] wdat;
    logic [7:0] rmux;
    logic pwr_chg;
    logic wake;

    assign lane.lo_en = !q.prev.lo_en_n;
    assign lane.hi_en = !q.prev.hi_en_n;
    assign lane.a0 = q.prev.addr[0];
    assign lane.rd_word = io_rd_data;
    assign lane.bus_in = q.prev.data;

    always_comb begin
        d = q;
        d.s1 = {reg_sel_n, high_byte_enable_n, low_byte_enable_n, mem_read_n, mem_write_n,
                io_read_strobe_n, io_write_strobe_n, card_addr, data_in};
        d.s2 = q.s1;
        d.prev = q.s2;
        d.rd_req = 1'b0;
        d.wr_pulse = 1'b0;

        io_mode = config_index != CFG_MEMORY;
        ready_now = core_ready && (q.pwr == CCS_ACTIVE || q.pwr == CCS_SAVE);
        int_pending = core_irq && !irq_disable_ctl;
        changed = q.rdy_chg || q.lock_chg;
        wdat = q.prev.data[7:0];
        attr_wr = q.s2.we_n && !q.prev.we_n && attr_hit(q.prev);

        rmux = 8'h00;
        unique case (q.s2.addr[3:0])
            OFS_CARD_COND: begin
                rmux[CC_CHANGED] = changed;
                rmux[CC_SIG_EN] = q.sig_en;
                rmux[CC_BYTE_IO] = q.byte_io;
                rmux[CC_PWR_LVL_DIS] = PWR_LVL_DIS_VAL;
                rmux[CC_AUDIO] = q.audio;
                rmux[CC_PWR_SAVE] = q.pwr_req;
                rmux[CC_INT] = int_pending;
            end
            OFS_PIN_REPL: begin
                rmux = PR_FIXED_ONES;
                rmux[PR_RDY_CHG] = q.rdy_chg;
                rmux[PR_LOCK_CHG] = q.lock_chg;
                rmux[PR_RDY_RAW] = ready_now;
                rmux[PR_LOCK_RAW] = RAW_LOCK_VAL;
            end
            OFS_SOCKET: rmux[SK_UNIT] = q.unit;
            default: rmux = 8'h00;
        endcase

        pwr_chg = 1'b0;
        if (attr_wr) begin
            unique case (q.prev.addr[3:0])
                OFS_CARD_COND: begin
                    d.sig_en = wdat[CC_SIG_EN];
                    d.byte_io = wdat[CC_BYTE_IO];
                    d.audio = wdat[CC_AUDIO];
                    d.pwr_req = wdat[CC_PWR_SAVE];
                    pwr_chg = wdat[CC_PWR_SAVE] != q.pwr_req;
                end
                OFS_PIN_REPL: begin
                    if (wdat[PR_RDY_RAW]) begin
                        d.rdy_chg = wdat[PR_RDY_CHG];
                    end
                    if (wdat[PR_LOCK_RAW]) begin
                        d.lock_chg = wdat[PR_LOCK_CHG];
                    end
                end
                // Socket number bits are dropped; only the unit bit is kept
                OFS_SOCKET: d.unit = HAS_UNIT_SELECT ? wdat[SK_UNIT] : 1'b0;
                default: d.unit = q.unit;
            endcase
        end

        // Hardware events win over a host clear in the same cycle
        d.prev_ready = ready_now;
        d.prev_lock = RAW_LOCK_VAL;
        if (ready_now != q.prev_ready) begin
            d.rdy_chg = 1'b1;
        end
        if (RAW_LOCK_VAL != q.prev_lock) begin
            d.lock_chg = 1'b1;
        end

        wake = !d.pwr_req && (!q.auto_save || core_cmd || pwr_chg);
        unique case (q.pwr)
            CCS_ACTIVE: begin
                if (d.pwr_req) begin
                    d.pwr = CCS_ENTER_SAVE;
                    d.cnt = '0;
                end else if (core_idle) begin
                    d.cnt = q.cnt + CNT_ONE;
                    if (q.cnt == IDLE_LAST) begin
                        d.auto_save = 1'b1;
                        d.pwr = CCS_ENTER_SAVE;
                        d.cnt = '0;
                    end
                end else begin
                    d.cnt = '0;
                end
            end
            CCS_ENTER_SAVE, CCS_LEAVE_SAVE: begin
                d.cnt = q.cnt + CNT_ONE;
                if (q.cnt == SETTLE_LAST) begin
                    d.pwr = (q.pwr == CCS_ENTER_SAVE) ? CCS_SAVE : CCS_ACTIVE;
                    d.cnt = '0;
                end
            end
            CCS_SAVE: begin
                if (pwr_chg && d.pwr_req) begin
                    // Host took over an automatic sleep: still show busy for the change
                    d.auto_save = 1'b0;
                    d.pwr = CCS_ENTER_SAVE;
                end else if (wake) begin
                    d.auto_save = 1'b0;
                    d.pwr = CCS_LEAVE_SAVE;
                end
            end
        endcase

        d.stat_chg_n = !(io_mode && changed && q.sig_en);
        // In I/O mode the ready pin becomes the interrupt request
        d.rdy_irq_n = io_mode ? !int_pending : !ready_now;
        d.ack_n = !io_hit(q.s2, config_index);
        d.match = q.unit == unit_select_bit;

        if (!q.s2.io_rd_n && q.prev.io_rd_n && io_hit(q.s2, config_index)) begin
            d.rd_pend = 1'b1;
            d.wait_n = 1'b0;
            d.rd_req = 1'b1;
            d.addr = q.s2.addr[3:0];
        end else if (q.rd_pend && io_rd_valid) begin
            d.rd_pend = 1'b0;
            d.wait_n = 1'b1;
            d.dout = lane.rd_bus;
            d.doe_n = ~lane.drive;
        end
        if (q.s2.io_rd_n && q.rd_pend) begin
            // Host gave up the cycle; drop the pending read
            d.rd_pend = 1'b0;
            d.wait_n = 1'b1;
        end

        if (!q.s2.oe_n && attr_hit(q.s2)) begin
            d.dout = {8'h00, rmux};
            d.doe_n = 2'b10;
        end else if (q.s2.oe_n && q.s2.io_rd_n) begin
            d.doe_n = 2'b11;
        end

        if (q.s2.io_wr_n && !q.prev.io_wr_n && io_hit(q.prev, config_index)) begin
            d.wr_pulse = 1'b1;
            d.addr = q.prev.addr[3:0];
            d.wr_data = lane.wr_word;
            d.wr_lanes = {lane.wr_odd, lane.wr_even};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
            q.s1 <= PINS_IDLE;
            q.s2 <= PINS_IDLE;
            q.prev <= PINS_IDLE;
            q.pwr <= CCS_ACTIVE;
            q.wait_n <= 1'b1;
            q.ack_n <= 1'b1;
            q.stat_chg_n <= 1'b1;
            q.rdy_irq_n <= 1'b1;
            // Ready idles high; a low reset value would flag a change right after reset
            q.prev_ready <= 1'b1;
            q.doe_n <= 2'b11;
            q.match <= 1'b1;
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign data_out = q.dout;
    assign data_oe_n = q.doe_n;
    assign wide_port_ack_n = q.ack_n;
    assign wait_n = q.wait_n;
    assign status_change_out_n = q.stat_chg_n;
    assign ready_irq_n = q.rdy_irq_n;
    assign io_rd_req = q.rd_req;
    assign io_wr_pulse = q.wr_pulse;
    assign io_addr = q.addr;
    assign io_wr_data = q.wr_data;
    assign io_wr_lanes = q.wr_lanes;
    assign power_down = q.pwr != CCS_ACTIVE;
    assign unit_match = q.match;
endmodule // ccs_regs

// file: sim/ccs_regs_sva.sv
/*
 Port-level checks for the card condition/status register block.
 Assumes a single sys_clk domain and rst_b active low; bound to every ccs_regs.
*/
`timescale 1ns/100ps
module ccs_regs_sva import ccs_pkg::*; #(
    parameter int unsigned IDLE_CYCLES = 20,
    parameter int unsigned SETTLE_CYCLES = 4,
    parameter bit HAS_UNIT_SELECT = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [5:0] config_index,
    input wire logic [15:0] data_out,
    input wire logic [1:0] data_oe_n,
    input wire logic wide_port_ack_n,
    input wire logic wait_n,
    input wire logic status_change_out_n,
    input wire logic ready_irq_n,
    input wire logic io_rd_req,
    input wire logic io_wr_pulse,
    input wire logic [1:0] io_wr_lanes,
    input wire logic power_down
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_start_s;
        io_rd_req && !wait_n;
    endsequence
    sequence wait_end_s;
        ##[1:60] wait_n;
    endsequence
    rd_pulse_a: assert property (io_rd_req |=> !io_rd_req)
        else $error("read request held past one cycle");
    wr_pulse_a: assert property (io_wr_pulse |=> !io_wr_pulse)
        else $error("write pulse held past one cycle");
    wait_start_a: assert property ($fell(wait_n) |-> io_rd_req)
        else $error("wait began without a read request");
    wait_bound_a: assert property (rd_start_s |-> wait_end_s)
        else $error("wait never released");
    memory_quiet_a: assert property ((config_index == CFG_MEMORY) [*2] |-> status_change_out_n)
        else $error("status change driven in memory mode");
    ack_mode_a: assert property (!wide_port_ack_n |-> $past(config_index) != CFG_MEMORY)
        else $error("port ack while memory mapped");
    upper_zero_a: assert property (config_index == CFG_MEMORY && data_oe_n == 2'b10 |-> data_out[15:8] == 8'h00)
        else $error("register read drives upper byte");
    wr_lanes_a: assert property (io_wr_pulse |-> io_wr_lanes != 2'b00)
        else $error("write pulse with no lane");
    busy_enter_a: assert property ($rose(power_down) && config_index == CFG_MEMORY |-> ##[0:1] ready_irq_n)
        else $error("ready not busy on power transition");
endmodule // ccs_regs_sva

bind ccs_regs ccs_regs_sva #(.IDLE_CYCLES(IDLE_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES),
    .HAS_UNIT_SELECT(HAS_UNIT_SELECT)) u_sva (.sys_clk(sys_clk), .rst_b(rst_b),
    .config_index(config_index), .data_out(data_out), .data_oe_n(data_oe_n),
    .wide_port_ack_n(wide_port_ack_n), .wait_n(wait_n), .status_change_out_n(status_change_out_n),
    .ready_irq_n(ready_irq_n), .io_rd_req(io_rd_req), .io_wr_pulse(io_wr_pulse),
    .io_wr_lanes(io_wr_lanes), .power_down(power_down));

// file: sim/ccs_core_model.sv
/*
 Storage core answering I/O reads behind the register block.
 Assumes io_rd_req is a one-cycle pulse on sys_clk; answers after DELAY cycles.
*/
`timescale 1ns/100ps
module ccs_core_model #(
    parameter int DELAY = 4
) (
    input wire logic sys_clk,
    input wire logic io_rd_req,
    input wire logic [15:0] word,
    output logic [15:0] io_rd_data,
    output logic io_rd_valid
);
    initial begin
        io_rd_valid = 1'b0;
        io_rd_data = 16'h0000;
        forever begin
            @(posedge sys_clk);
            if (io_rd_req === 1'b1) begin
                repeat (DELAY) @(posedge sys_clk);
                io_rd_valid <= 1'b1;
                io_rd_data <= word;
                @(posedge sys_clk);
                io_rd_valid <= 1'b0;
                // Stale data inverted so a late capture shows up
                io_rd_data <= ~word;
            end
        end
    end
endmodule // ccs_core_model

// file: sim/tb_top.sv
/*
 Self-checking bench: drives card pins through attribute and I/O cycles.
 Assumes short power counts (idle 20, settle 4) and a 4-cycle core answer.
*/
`timescale 1ns/100ps
module tb_top import ccs_pkg::*;;
    logic sys_clk = 0, rst_b = 0, rs = 1, le = 1, he = 1, mr = 1, mw = 1, ir = 1, iw = 1;
    logic crdy = 1, cirq = 0, idis = 0, cidle = 0, ccmd = 0, usel = 0, busy_seen = 0;
    logic [10:0] ad = 11'h000;
    logic [15:0] di = 16'h0000, dout, rdd, wrd, q, cw, mword = 16'hA55A;
    logic [5:0] cfg = 6'h00;
    logic [1:0] oe, wl, o, cl;
    logic [3:0] ioa;
    logic ackn, waitn, scn, rqn, rreq, rval, wp, pd, um, ak, wait_seen;
    int fails = 0, comparisons = 0, wait_cnt = 0;
    logic [1:0] ens [4] = '{2'b00, 2'b10, 2'b10, 2'b01};
    logic [10:0] as [4] = '{11'h000, 11'h000, 11'h001, 11'h000};
    logic [15:0] rexp [4] = '{16'hA55A, 16'h005A, 16'h00A5, 16'hA500};
    logic [15:0] rmsk [4] = '{16'hFFFF, 16'h00FF, 16'h00FF, 16'hFF00};
    logic [1:0] roe [4] = '{2'b00, 2'b10, 2'b10, 2'b01};
    logic [15:0] wexp [4] = '{16'hA55A, 16'h005A, 16'h5A00, 16'hA500};
    logic [1:0] wln [4] = '{2'b11, 2'b01, 2'b10, 2'b10};

    always #4 sys_clk = ~sys_clk;

    ccs_regs #(.IDLE_CYCLES(20), .SETTLE_CYCLES(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .clk_en(1'b1), .reg_sel_n(rs), .low_byte_enable_n(le), .high_byte_enable_n(he),
        .mem_read_n(mr), .mem_write_n(mw), .io_read_strobe_n(ir), .io_write_strobe_n(iw),
        .card_addr(ad), .data_in(di), .data_out(dout), .data_oe_n(oe), .wide_port_ack_n(ackn),
        .wait_n(waitn), .status_change_out_n(scn), .ready_irq_n(rqn), .config_index(cfg),
        .core_ready(crdy), .core_irq(cirq), .irq_disable_ctl(idis), .core_idle(cidle),
        .core_cmd(ccmd), .unit_select_bit(usel), .io_rd_data(rdd), .io_rd_valid(rval),
        .io_rd_req(rreq), .io_wr_pulse(wp), .io_addr(ioa), .io_wr_data(wrd),
        .io_wr_lanes(wl), .power_down(pd), .unit_match(um));

    ccs_core_model #(.DELAY(4)) u_core (.sys_clk(sys_clk), .io_rd_req(rreq), .word(mword),
        .io_rd_data(rdd), .io_rd_valid(rval));

    always @(posedge sys_clk) begin
        if (wp === 1'b1) begin
            cw <= wrd;
            cl <= wl;
        end else if (ir === 1'b0) begin
            // A read before each write clears the capture, so a missing pulse shows
            cw <= 16'h0000;
            cl <= 2'b00;
        end
        if (pd === 1'b1 && rqn === 1'b1) busy_seen <= 1'b1;
        if (waitn === 1'b0) wait_cnt <= wait_cnt + 1;
    end

    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask

    // One pin cycle: k 0 attr read, 1 attr write, 2 io read, 3 io write
    task automatic cyc(input logic [10:0] a, input logic [15:0] d, input logic [1:0] en,
        input int k);
        int w0;
        @(posedge sys_clk);
        w0 = wait_cnt;
        ad <= a;
        di <= d;
        {he, le} <= en;
        {iw, ir, mw, mr} <= ~(4'h1 << k);
        repeat (12) @(posedge sys_clk);
        #1;
        q = dout;
        o = oe;
        ak = ackn;
        wait_seen = wait_cnt != w0;
        @(posedge sys_clk);
        {iw, ir, mw, mr} <= 4'hF;
        repeat (6) @(posedge sys_clk);
        {he, le} <= 2'b11;
        repeat (3) @(posedge sys_clk);
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [7:0] v);
        cyc(ATTR_BASE | {7'h00, ofs}, {8'h00, v}, 2'b10, 1);
    endtask

    task automatic rd(input logic [3:0] ofs, input logic [7:0] e, input string n);
        cyc(ATTR_BASE | {7'h00, ofs}, 16'h0000, 2'b10, 0);
        chk(n, q, {8'h00, e});
    endtask

    task automatic print_verdict();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        print_verdict();
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        rs <= 1'b0;
        rd(OFS_PIN_REPL, 8'h0E, "pin_reset");
        wr(OFS_PIN_REPL, 8'h03);
        rd(OFS_PIN_REPL, 8'h0E, "pin_idle");
        rd(OFS_CARD_COND, 8'h00, "cond_reset");
        rd(4'h8, 8'h00, "unmapped");
        wr(OFS_PIN_REPL, 8'h20);
        rd(OFS_PIN_REPL, 8'h0E, "mask_zero");
        wr(OFS_PIN_REPL, 8'h23);
        rd(OFS_PIN_REPL, 8'h2E, "flag_set");
        rd(OFS_CARD_COND, 8'h80, "changed");
        wr(OFS_PIN_REPL, 8'h03);
        @(posedge sys_clk);
        crdy <= 1'b0;
        rd(OFS_PIN_REPL, 8'h2C, "ready_drop");
        @(posedge sys_clk);
        crdy <= 1'b1;
        wr(OFS_PIN_REPL, 8'h03);
        wr(OFS_CARD_COND, 8'h30);
        rd(OFS_CARD_COND, 8'h20, "byte_io_lvl");
        @(posedge sys_clk);
        cirq <= 1'b1;
        rd(OFS_CARD_COND, 8'h22, "irq_on");
        @(posedge sys_clk);
        idis <= 1'b1;
        rd(OFS_CARD_COND, 8'h20, "irq_off");
        @(posedge sys_clk);
        {cirq, idis, usel} <= 3'b001;
        wr(OFS_SOCKET, 8'h1F);
        rd(OFS_SOCKET, 8'h10, "socket");
        chk("unit_match", {15'h0000, um}, 16'h0001);
        @(posedge sys_clk);
        cfg <= CFG_IO_ANY;
        wr(OFS_CARD_COND, 8'h60);
        wr(OFS_PIN_REPL, 8'h23);
        chk("stat_chg_low", {15'h0000, scn}, 16'h0000);
        rd(OFS_CARD_COND, 8'hE0, "cond_io");
        wr(OFS_CARD_COND, 8'h20);
        chk("stat_chg_high", {15'h0000, scn}, 16'h0001);
        chk("irq_pin", {15'h0000, rqn}, 16'h0001);
        wr(OFS_PIN_REPL, 8'h03);
        for (int i = 0; i < 4; i++) begin
            cyc(as[i], 16'h0000, ens[i], 2);
            chk("io_rd", q & rmsk[i], rexp[i] & rmsk[i]);
            chk("io_oe", {14'h0000, o}, {14'h0000, roe[i]});
            chk("io_ack", {15'h0000, ak}, 16'h0000);
            chk("io_wait", {15'h0000, wait_seen}, 16'h0001);
            cyc(as[i], mword, ens[i], 3);
            chk("io_wr", cw & wexp[i] & 16'hFFFF, wexp[i]);
            chk("io_lanes", {14'h0000, cl}, {14'h0000, wln[i]});
            chk("io_addr", {12'h000, ioa}, {12'h000, as[i][3:0]});
        end
        @(posedge sys_clk);
        rs <= 1'b1;
        cyc(11'h000, 16'h0000, 2'b00, 2);
        chk("inhibit", {14'h0000, ak, wait_seen}, 16'h0002);
        @(posedge sys_clk);
        rs <= 1'b0;
        cfg <= CFG_IO_PRI;
        cyc({1'b0, IO_PRI_TASK}, 16'h0000, 2'b00, 0);
        chk("pri_ack", {15'h0000, ak}, 16'h0000);
        @(posedge sys_clk);
        cfg <= CFG_IO_SEC;
        cyc({1'b0, IO_SEC_CTL}, 16'h0000, 2'b00, 0);
        chk("sec_ack", {15'h0000, ak}, 16'h0000);
        cyc({1'b0, IO_PRI_TASK}, 16'h0000, 2'b00, 0);
        chk("sec_miss", {15'h0000, ak}, 16'h0001);
        @(posedge sys_clk);
        cfg <= CFG_MEMORY;
        cyc(11'h000, 16'h0000, 2'b00, 2);
        chk("mem_ack", {14'h0000, ak, wait_seen}, 16'h0002);
        chk("ready", {15'h0000, rqn}, 16'h0000);
        wr(OFS_CARD_COND, 8'h04);
        chk("pwr_down", {14'h0000, pd, busy_seen}, 16'h0003);
        wr(OFS_CARD_COND, 8'h00);
        chk("pwr_up", {14'h0000, pd, rqn}, 16'h0000);
        @(posedge sys_clk);
        cidle <= 1'b1;
        repeat (40) @(posedge sys_clk);
        #1;
        chk("auto_down", {15'h0000, pd}, 16'h0001);
        @(posedge sys_clk);
        {cidle, ccmd} <= 2'b01;
        @(posedge sys_clk);
        ccmd <= 1'b0;
        repeat (15) @(posedge sys_clk);
        #1;
        chk("wake", {15'h0000, pd}, 16'h0000);
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        rd(OFS_PIN_REPL, 8'h0E, "pin_rst");
        rd(OFS_SOCKET, 8'h00, "sock_rst");
        print_verdict();
    end
endmodule // tb_top
